/* File: shared/dmb_defines.svh */
`ifndef DMB_DEFINES_SVH
`define DMB_DEFINES_SVH
`define DMB_ADDR_W       12
`define DMB_BANK_BYTES   256
`define DMB_BANK_COUNT   16
`define DMB_SECOND_TAG   4'hf
`define DMB_ACCESS_SPLIT 8'h60
`define DMB_LOW_BANK     4'h0
`define DMB_SFR_BANK     4'hf
`define DMB_SFR_BASE     12'hf60
`define DMB_USB_BANK     4'h4
`define DMB_BANKPTR_ADDR 12'hfe0
`define DMB_BANKPTR_RST  4'h0
`define DMB_GPR_BANKS    2
`endif

/* File: shared/dmb_pkg.sv */
package dmb_pkg;
  typedef logic [11:0] dmb_addr_t;
  typedef logic [7:0]  dmb_byte_t;
  typedef enum logic [1:0] {
    DMB_IDLE,
    DMB_WAIT2,
    DMB_MOVE
  } dmb_seq_e;
endpackage

/* File: core/dmb_addr_gen.sv */
`timescale 1ns/10ps
`include "dmb_defines.svh"
module dmb_addr_gen
  import dmb_pkg::*;
(
  input  wire logic       abit_i,
  input  wire logic [3:0] bank_i,
  input  wire logic [7:0] offset_i,
  output dmb_addr_t       addr_o
);
  always_comb begin
    if (abit_i) begin
      addr_o = {bank_i, offset_i};
    end else if (offset_i < `DMB_ACCESS_SPLIT) begin
      addr_o = {`DMB_LOW_BANK, offset_i};
    end else begin
      addr_o = {`DMB_SFR_BANK, offset_i};
    end
  end
endmodule // dmb_addr_gen

/* File: core/dmb_dpram.sv */
`timescale 1ns/10ps
module dmb_dpram #(
  parameter int DEPTH = 256
) (
  input  wire logic                     clk_i,
  input  wire logic                     a_we_i,
  input  wire logic [$clog2(DEPTH)-1:0] a_addr_i,
  input  wire logic [$clog2(DEPTH)-1:0] a_raddr_i,
  input  wire logic [7:0]               a_wdata_i,
  output logic      [7:0]               a_rdata_o,
  input  wire logic                     b_we_i,
  input  wire logic [$clog2(DEPTH)-1:0] b_addr_i,
  input  wire logic [7:0]               b_wdata_i,
  output logic      [7:0]               b_rdata_o
);
  if (DEPTH < 2) begin : g_chk
    $error("DEPTH must be at least 2");
  end

  logic [7:0] mem [DEPTH];
  // Port A writes at one address and reads at another, so one core cycle
  // can copy a byte within the bank
  // Port A wins a same-address collision; it is the core side
  always_ff @(posedge clk_i) begin
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    if (b_we_i && !(a_we_i && a_addr_i == b_addr_i)) begin
      mem[b_addr_i] <= b_wdata_i;
    end
  end
  assign a_rdata_o = mem[a_raddr_i];
  assign b_rdata_o = mem[b_addr_i];
endmodule // dmb_dpram

/* File: core/dmb_bank_unit.sv */
// Functional notes
// - Second word tagged 1111, low twelve literal
// - In-sequence second word feeds its own instruction
// - Lone second word executes as NOP
// - Data addresses are twelve bits, 4096 bytes
// - Sixteen banks of 256 bytes, upper nibble
// - Three complete banks, 768 backed bytes
// - Unbacked addresses read as zero
// - USB off: bank 4 is plain storage
// - USB on: bank 4 shared with engine
// - Banked: pointer high nibble, offset low byte
// - Pointer keeps low nibble; high reads zero
// - Load bank literal writes the pointer
// - Unbacked writes dropped, reads zero
// - Flags update as if access succeeded
// - Full address move ignores bank pointer
// - Access map: bank 0 low, bank 15 top
// - Access bit selects banked or access map
// - Access map answers in one cycle
// - Special registers F60h-FFFh, unused read zero
`timescale 1ns/10ps
`include "dmb_defines.svh"
module dmb_bank_unit
  import dmb_pkg::*;
#(
  parameter int GPR_BANKS = `DMB_GPR_BANKS
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Instruction word stream from the pipeline
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_word_i,
  input  wire logic        instr_first_i,
  input  wire logic        instr_move_i,
  output logic             lit_valid_o,
  output dmb_addr_t        lit_o,
  output logic             nop_o,
  output logic             move_busy_o,
  // Load bank literal
  input  wire logic        blit_valid_i,
  input  wire logic [7:0]  blit_data_i,
  // Data access from execution
  input  wire logic        acc_valid_i,
  input  wire logic        acc_write_i,
  input  wire logic        acc_abit_i,
  input  wire logic [7:0]  acc_offset_i,
  input  wire logic [7:0]  acc_wdata_i,
  output logic             rd_valid_o,
  output dmb_byte_t        rd_data_o,
  output dmb_addr_t        acc_addr_o,
  output logic             hit_o,
  output logic             flags_update_o,
  output logic [7:0]       bank_ptr_o,
  // USB serial engine port
  input  wire logic        usb_en_i,
  input  wire logic        usb_req_i,
  input  wire logic        usb_write_i,
  input  wire logic [7:0]  usb_addr_i,
  input  wire logic [7:0]  usb_wdata_i,
  output dmb_byte_t        usb_rdata_o
);

  // Low banks sit contiguously from address zero, so one array serves them
  localparam int GPR_BYTES = GPR_BANKS * `DMB_BANK_BYTES;
  localparam int GPR_AW    = $clog2(GPR_BYTES);

  // Low banks must not reach the USB bank
  if (GPR_BANKS < 1 || GPR_BANKS > 3) begin : g_chk
    $error("GPR_BANKS must be 1 to 3");
  end

  // Offsets are one byte wide, so a bank must hold exactly 256 bytes
  if (`DMB_BANK_BYTES != 256) begin : g_chk_bank
    $error("Bank size must be 256 bytes");
  end

  dmb_seq_e   seq_reg;
  dmb_seq_e   seq_next;
  logic [3:0] bank_reg;
  dmb_addr_t  src_reg;
  dmb_addr_t  dst_reg;
  dmb_addr_t  src_next;
  logic       first_move_reg;
  logic [7:0] gpr_mem [GPR_BYTES];

  dmb_addr_t  acc_addr;
  dmb_addr_t  rd_addr;
  dmb_byte_t  rd_byte;
  dmb_byte_t  usb_rd;
  dmb_byte_t  buf_rd;
  logic       acc_take;
  logic       second_tag;
  logic       seq_second;
  logic       wr_en;
  dmb_addr_t  wr_addr;
  dmb_byte_t  wr_data;
  logic       buf_we;
  logic       usb_we;

  // Bank number is the upper nibble of any full address
  function automatic logic [3:0] bank_of(input dmb_addr_t a);
    bank_of = a[11:8];
  endfunction

  // Bank 4 is steered to the dual-port buffer, whatever the USB state
  function automatic logic is_usb_bank(input dmb_addr_t a);
    is_usb_bank = (bank_of(a) == `DMB_USB_BANK);
  endfunction

  // Backed storage: low GPR banks and the USB bank
  function automatic logic is_backed(input dmb_addr_t a);
    logic [3:0] b;
    b = bank_of(a);
    is_backed = (int'(b) < GPR_BANKS) || is_usb_bank(a);
  endfunction

  function automatic logic is_bankptr(input dmb_addr_t a);
    is_bankptr = (a == `DMB_BANKPTR_ADDR);
  endfunction

  // Backed storage or the bank pointer; every other address reads as zero
  function automatic logic is_mapped(input dmb_addr_t a);
    is_mapped = is_backed(a) || is_bankptr(a);
  endfunction

  // Both maps resolve combinationally, so either answers next cycle
  dmb_addr_gen u_addr_gen (
    .abit_i   (acc_abit_i),
    .bank_i   (bank_reg),
    .offset_i (acc_offset_i),
    .addr_o   (acc_addr)
  );

  // Accesses are refused while a full address move owns the memory
  assign move_busy_o = (seq_reg == DMB_MOVE);
  assign acc_take    = acc_valid_i && !move_busy_o;

  assign second_tag = (instr_word_i[15:12] == `DMB_SECOND_TAG);
  // A tagged word only counts as a second word while one is pending
  assign seq_second = instr_valid_i && (seq_reg == DMB_WAIT2) && second_tag;

  // Source for a move comes from the first word, not the pointer
  assign rd_addr = move_busy_o ? src_reg : acc_addr;

  // Bank 4 first, then the pointer, then plain storage; the rest reads zero
  always_comb begin
    if (is_usb_bank(rd_addr)) begin
      rd_byte = buf_rd;
    end else if (is_bankptr(rd_addr)) begin
      rd_byte = {4'h0, bank_reg};
    end else if (is_backed(rd_addr)) begin
      rd_byte = gpr_mem[rd_addr[GPR_AW-1:0]];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Write source: move beats execution, they never overlap anyway
  always_comb begin
    if (move_busy_o) begin
      // Unbacked destination other than the bank pointer falls through every storage enable below
      wr_en   = 1'b1;
      wr_addr = dst_reg;
      wr_data = rd_byte;
    end else begin
      wr_en   = acc_take && acc_write_i;
      wr_addr = acc_addr;
      wr_data = acc_wdata_i;
    end
  end

  // Dropped when unbacked; no storage moves
  assign buf_we = wr_en && is_usb_bank(wr_addr);

  // Engine writes only while the USB function is on
  assign usb_we = usb_en_i && usb_req_i && usb_write_i;

  dmb_dpram #(
    .DEPTH (`DMB_BANK_BYTES)
  ) u_usb_ram (
    .clk_i     (clk_i),
    .a_we_i    (buf_we),
    .a_addr_i  (wr_addr[7:0]),
    .a_raddr_i (rd_addr[7:0]),
    .a_wdata_i (wr_data),
    .a_rdata_o (buf_rd),
    .b_we_i    (usb_we),
    .b_addr_i  (usb_addr_i),
    .b_wdata_i (usb_wdata_i),
    .b_rdata_o (usb_rd)
  );

  // The core side reads and writes bank 4 at separate addresses, so a
  // move within bank 4 reads its source while the destination is written;
  // a read of the byte being written sees the old value until the edge.

  // Low GPR banks
  always_ff @(posedge clk_i) begin
    if (wr_en && is_backed(wr_addr) && !is_usb_bank(wr_addr)) begin
      gpr_mem[wr_addr[GPR_AW-1:0]] <= wr_data;
    end
  end

  // Bank pointer: literal load wins over a data write in the same cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bank_reg <= `DMB_BANKPTR_RST;
    end else if (blit_valid_i) begin
      bank_reg <= blit_data_i[3:0];
    end else if (wr_en && is_bankptr(wr_addr)) begin
      bank_reg <= wr_data[3:0];
    end
  end

  // Upper nibble is not stored, so it can only read zero
  assign bank_ptr_o = {4'h0, bank_reg};

  // Two-word sequencing
  always_comb begin
    seq_next = seq_reg;
    src_next = src_reg;
    case (seq_reg)
      DMB_IDLE: begin
        if (instr_valid_i && instr_first_i) begin
          seq_next = DMB_WAIT2;
          src_next = instr_word_i[11:0];
        end
      end
      DMB_WAIT2: begin
        // A tagged word after a move opener starts the move; an untagged opening word restarts the wait; anything else drops it
        if (instr_valid_i) begin
          if (second_tag && first_move_reg) begin
            seq_next = DMB_MOVE;
          end else if (instr_first_i && !second_tag) begin
            seq_next = DMB_WAIT2;
            src_next = instr_word_i[11:0];
          end else begin
            seq_next = DMB_IDLE;
          end
        end
      end
      DMB_MOVE: begin
        seq_next = DMB_IDLE;
      end
      default: begin
        seq_next = DMB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_reg <= DMB_IDLE;
      src_reg <= 12'h000;
    end else begin
      seq_reg <= seq_next;
      src_reg <= src_next;
    end
  end

  // Remembers whether the pending opening word asked for a move
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_move_reg <= 1'b0;
    end else if (instr_valid_i && instr_first_i && seq_next == DMB_WAIT2) begin
      first_move_reg <= instr_move_i;
    end
  end

  // Destination of a move comes from the second word
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dst_reg <= 12'h000;
    end else if (seq_second) begin
      dst_reg <= instr_word_i[11:0];
    end
  end

  // Literal handed back to the pipeline with its own instruction
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lit_valid_o <= 1'b0;
    end else begin
      lit_valid_o <= seq_second;
    end
  end

  // Literal holds until the next in-sequence second word
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lit_o <= 12'h000;
    end else if (seq_second) begin
      lit_o <= instr_word_i[11:0];
    end
  end

  // A tagged word with no opening word before it does nothing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      nop_o <= 1'b0;
    end else begin
      nop_o <= instr_valid_i && second_tag && seq_reg != DMB_WAIT2;
    end
  end

  // Access answer, same one-cycle latency on either map
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_valid_o     <= 1'b0;
      flags_update_o <= 1'b0;
    end else begin
      rd_valid_o     <= acc_take && !acc_write_i;
      flags_update_o <= acc_take;
    end
  end

  // Held until the next taken access; a write shows zero so that no stale
  // byte is taken for fresh read data
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hit_o      <= 1'b0;
      acc_addr_o <= 12'h000;
      rd_data_o  <= 8'h00;
    end else if (acc_take) begin
      acc_addr_o <= acc_addr;
      hit_o      <= is_mapped(acc_addr);
      rd_data_o  <= acc_write_i ? 8'h00 : rd_byte;
    end
  end

  // Engine reads return zero while the USB function is off; clearing on
  // disable also keeps a byte read earlier from lingering on the port
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      usb_rdata_o <= 8'h00;
    end else if (!usb_en_i) begin
      usb_rdata_o <= 8'h00;
    end else if (usb_req_i && !usb_write_i) begin
      usb_rdata_o <= usb_rd;
    end
  end

endmodule // dmb_bank_unit

/* File: verification/dmb_bank_unit_checker.sv */
`timescale 1ns/10ps
module dmb_bank_unit_checker
  import dmb_pkg::*;
(
  input wire logic        clk_i, reset_i, acc_valid_i, acc_write_i, acc_abit_i, move_busy_o, rd_valid_o,
  input wire logic        hit_o, flags_update_o, blit_valid_i, instr_valid_i, instr_first_i, instr_move_i,
  input wire logic        nop_o, lit_valid_o, usb_en_i, usb_req_i,
  input wire logic [7:0]  acc_offset_i, bank_ptr_o, blit_data_i,
  input wire logic [15:0] instr_word_i,
  input wire dmb_byte_t   rd_data_o, usb_rdata_o,
  input wire dmb_addr_t   acc_addr_o, lit_o
);
  logic [7:0]  off_q;
  logic [3:0]  ptr_q;
  logic [11:0] lit_q;
  always_ff @(posedge clk_i) begin
    off_q <= acc_offset_i;
    ptr_q <= bank_ptr_o[3:0];
    lit_q <= instr_word_i[11:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_take; acc_valid_i && !move_busy_o; endsequence
  sequence s_first; instr_valid_i && instr_first_i && !instr_move_i; endsequence
  sequence s_second; instr_valid_i && !instr_first_i && instr_word_i[15:12] == 4'hf; endsequence
  property p_flags; s_take |=> flags_update_o; endproperty
  a_flags: assert property (p_flags) else $error("flags pulse missing");
  property p_single; s_take ##0 !acc_write_i |=> rd_valid_o; endproperty
  a_single: assert property (p_single) else $error("read not done in one cycle");
  property p_amap; s_take ##0 !acc_abit_i |=> acc_addr_o == {(off_q >= 8'h60) ? 4'hf : 4'h0, off_q}; endproperty
  a_amap: assert property (p_amap) else $error("access map address wrong");
  property p_bank; s_take ##0 acc_abit_i |=> acc_addr_o == {ptr_q, off_q}; endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_ptr_hi; bank_ptr_o[7:4] == 4'h0; endproperty
  a_ptr_hi: assert property (p_ptr_hi) else $error("pointer upper bits set");
  property p_blit; blit_valid_i |=> bank_ptr_o == (8'h0f & $past(blit_data_i)); endproperty
  a_blit: assert property (p_blit) else $error("bank literal not loaded");
  property p_zero; rd_valid_o && !hit_o |-> rd_data_o == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("unmapped read not zero");
  property p_lit; s_first ##1 s_second |=> lit_valid_o && lit_o == lit_q; endproperty
  a_lit: assert property (p_lit) else $error("second word literal lost");
  property p_nop; nop_o |-> $past(instr_valid_i) && !$past(instr_first_i) && $past(instr_word_i) >= 16'hf000; endproperty
  a_nop: assert property (p_nop) else $error("spurious no-operation");
  property p_usb; usb_req_i && !usb_en_i |=> usb_rdata_o == 8'h00; endproperty
  a_usb: assert property (p_usb) else $error("engine read while disabled");
endmodule // dmb_bank_unit_checker
bind dmb_bank_unit dmb_bank_unit_checker dmb_bank_unit_checker_i (.clk_i, .reset_i, .acc_valid_i, .acc_write_i,
  .acc_abit_i, .move_busy_o, .rd_valid_o, .hit_o, .flags_update_o, .blit_valid_i, .instr_valid_i, .instr_first_i,
  .instr_move_i, .nop_o, .lit_valid_o, .usb_en_i, .usb_req_i, .acc_offset_i, .bank_ptr_o, .blit_data_i,
  .instr_word_i, .rd_data_o, .usb_rdata_o, .acc_addr_o, .lit_o);

/* File: verification/dmb_usb_model.sv */
`timescale 1ns/10ps
module dmb_usb_model (
  input  wire logic       clk_i, go_i, wr_i,
  input  wire logic [7:0] a_i, d_i,
  output logic            usb_req_o, usb_write_o,
  output logic      [7:0] usb_addr_o, usb_wdata_o
);
  initial {usb_req_o, usb_write_o, usb_addr_o, usb_wdata_o} = '0;
  // Released lines flip so a stale value never passes for a live one
  always @(posedge clk_i) begin
    usb_req_o <= go_i;
    usb_write_o <= go_i ? wr_i : ~usb_write_o;
    usb_addr_o <= go_i ? a_i : ~usb_addr_o;
    usb_wdata_o <= go_i ? d_i : ~usb_wdata_o;
  end
endmodule // dmb_usb_model

/* File: verification/dmb_bank_unit_tb.sv */
`timescale 1ns/10ps
module dmb_bank_unit_tb;
  import dmb_pkg::*;
  logic clk_i = 0, reset_i = 1, iv = 0, ifi = 0, imv = 0, bv = 0, av = 0, aw = 0, ab = 0, ue = 0, go = 0, gw = 0;
  logic [15:0] iw = 0;
  logic [7:0]  bd = 0, ao = 0, ad = 0, ga = 0, gd = 0, uaddr, uwd, rd, urd, ptr_o;
  logic        ureq, uwr, litv, nop, busy, rdv, hit, flg;
  dmb_addr_t   lit, aa;
  int          error_cnt = 0, comparisons = 0, seed = 32'h08f8bb82, ptr = 0;
  int          mem [0:4095];
  always #4 clk_i = ~clk_i;
  dmb_bank_unit dmb_bank_unit_i (.clk_i, .reset_i, .instr_valid_i(iv), .instr_word_i(iw), .instr_first_i(ifi),
    .instr_move_i(imv), .lit_valid_o(litv), .lit_o(lit), .nop_o(nop), .move_busy_o(busy), .blit_valid_i(bv),
    .blit_data_i(bd), .acc_valid_i(av), .acc_write_i(aw), .acc_abit_i(ab), .acc_offset_i(ao), .acc_wdata_i(ad),
    .rd_valid_o(rdv), .rd_data_o(rd), .acc_addr_o(aa), .hit_o(hit), .flags_update_o(flg), .bank_ptr_o(ptr_o),
    .usb_en_i(ue), .usb_req_i(ureq), .usb_write_i(uwr), .usb_addr_i(uaddr), .usb_wdata_i(uwd), .usb_rdata_o(urd));
  dmb_usb_model dmb_usb_model_i (.clk_i, .go_i(go), .wr_i(gw), .a_i(ga), .d_i(gd), .usb_req_o(ureq),
    .usb_write_o(uwr), .usb_addr_o(uaddr), .usb_wdata_o(uwd));
  function automatic bit backed(int a);
    return a[11:8] < 2 || a[11:8] == 4;
  endfunction
  task automatic chk(string n, logic [11:0] s, logic [11:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(bit w, bit a, logic [7:0] o, logic [7:0] d);
    int adr;
    adr = a ? ptr * 256 + o : (o >= 8'h60 ? 12'hf00 : 0) + o;
    @(posedge clk_i);
    {av, aw, ab, ao, ad} <= {1'b1, w, a, o, d};
    @(posedge clk_i);
    av <= 0;
    #1;
    chk("addr", aa, adr[11:0]);
    chk("flags", flg, 1);
    chk("rd_valid", rdv, !w);
    chk("hit", hit, backed(adr) || adr == 12'hfe0);
    if (!w) chk("rdata", rd, backed(adr) ? mem[adr] : adr == 12'hfe0 ? ptr : 0);
    else if (backed(adr)) mem[adr] = d;
    else if (adr == 12'hfe0) ptr = d[3:0];
  endtask
  task automatic blit(logic [7:0] v);
    @(posedge clk_i);
    {bv, bd} <= {1'b1, v};
    @(posedge clk_i);
    bv <= 0;
    ptr = v[3:0];
    #1 chk("ptr", ptr_o, ptr);
  endtask
  task automatic op(bit two, bit mv, logic [15:0] w1, logic [15:0] w2);
    @(posedge clk_i);
    iv <= 1;
    if (two) begin
      {iw, ifi, imv} <= {w1, 1'b1, mv};
      @(posedge clk_i);
    end
    {iw, ifi, imv} <= {w2, 2'b00};
    @(posedge clk_i);
    iv <= 0;
    #1;
    chk("lit_valid", litv, two);
    chk("nop", nop, !two);
    if (two) chk("lit", lit, w2[11:0]);
    chk("busy", busy, mv);
    if (mv && backed(w2[11:0])) mem[w2[11:0]] = mem[w1[11:0]];
  endtask
  task automatic usb(bit w, logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    {go, gw, ga, gd} <= {1'b1, w, a, d};
    @(posedge clk_i);
    go <= 0;
    @(posedge clk_i);
    #1;
    if (!w) chk("usb_rdata", urd, ue ? mem[12'h400 + a] : 0);
    else if (ue) mem[12'h400 + a] = d;
  endtask
  task final_report;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 0;
    #1 chk("ptr_reset", ptr_o, 0);
    // Preload every backed byte so later reads never meet unknown contents
    for (int i = 0; i < 3; i++) begin
      blit(i == 2 ? 4 : i);
      for (int o = 0; o < 256; o++) acc(1, 1, o, $random(seed));
    end
    repeat (150) begin
      if ($random(seed) % 4 == 0) blit($random(seed));
      acc($random(seed), $random(seed), $random(seed), $random(seed));
    end
    op(0, 0, 16'h0000, 16'hf456);
    op(1, 0, 16'hc123, 16'hf456);
    blit(8'hf4);
    op(1, 1, 16'hc010, 16'hf455);
    acc(0, 1, 8'h55, 0);
    op(1, 1, 16'hc410, 16'hf456);
    acc(0, 1, 8'h56, 0);
    @(posedge clk_i);
    ue <= 1;
    usb(1, 8'h33, 8'h5a);
    usb(0, 8'h33, 0);
    acc(0, 1, 8'h33, 0);
    acc(1, 1, 8'h34, 8'ha5);
    usb(0, 8'h34, 0);
    @(posedge clk_i);
    ue <= 0;
    usb(1, 8'h33, 8'h77);
    usb(0, 8'h33, 0);
    acc(0, 1, 8'h33, 0);
    final_report;
  end
endmodule // dmb_bank_unit_tb
